// ### design/vpcr_regs.sv
/*
 * vpcr_regs: protocol select, tx pulse length and no-response timeout
 * registers with their modulation pulse timer and no-response timer.
 * Assumes host port strobes are one-cycle pulses synchronous to clk and the
 * enable pin and power-on reset inputs are already synchronous.
 */
//
// Contract
// - protocol select loads 0x02 when enable low or power-on reset high.
// - protocol bit 7 set means no receive crc, clear means check crc.
// - protocol bit 6 picks direct mode variant 0 or 1.
// - codes 0 to 3 one subcarrier; bit 1 rate, bit 0 coding.
// - codes 4 to 7 double subcarrier; same rate and coding bits.
// - pulse length zero uses protocol width, else value times 73.7 ns.
// - pulse length clears on reset, enable low and protocol select writes.
// - protocol pulse width with zero override is 9.44 us.
// - no response before interval end raises interrupt and sets status flag.
// - interval is timeout value, 1 to 255, times 37.76 us.
// - interval timer starts when transmitted end of frame completes.
// - timeout loads 0x0E on reset, enable low and protocol select writes.
// - protocol default timeout is 755 us high rate, 1812 us low.
//
`timescale 1ns/1ps
`default_nettype none

module vpcr_regs #(
    parameter int unsigned NORESP_HI_CYC = vpcr_pkg::NORESP_DEF_HI_NS / vpcr_pkg::CLK_PERIOD_NS,
    parameter int unsigned NORESP_LO_CYC = vpcr_pkg::NORESP_DEF_LO_NS / vpcr_pkg::CLK_PERIOD_NS
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       enable,
    input  wire logic       por,
    input  wire logic [4:0] host_addr,
    input  wire logic       host_wr,
    input  wire logic       host_rd,
    input  wire logic [7:0] host_wdata,
    output logic      [7:0] host_rdata,
    input  wire logic       tx_pulse_start,
    input  wire logic       tx_eof_done,
    input  wire logic       rx_resp_start,
    output logic            mod_pulse,
    output logic            rx_no_crc,
    output logic            direct_variant,
    output logic            double_subcarrier,
    output logic            high_rate,
    output logic            one_of_256,
    output logic            code_valid,
    output logic            no_resp_flag,
    output logic            no_resp_irq
);

    localparam int          TW      = vpcr_pkg::TMO_CNT_W;
    localparam int          AW      = vpcr_pkg::PULSE_ACC_W;
    // largest value an 8-bit host register can hold
    localparam int unsigned REG_MAX = (1 << $bits(host_wdata)) - 1;

    if (NORESP_HI_CYC < 1 || NORESP_LO_CYC < 1 || NORESP_LO_CYC >= (1 << TW)
        || NORESP_HI_CYC >= (1 << TW))
    begin : g_chk_tmo
        $error("vpcr_regs: default timeout counts out of range");
    end

    // the largest programmed interval must fit the timer counter
    if (REG_MAX * vpcr_pkg::NORESP_STEP_CYC >= (1 << TW))
    begin : g_chk_step
        $error("vpcr_regs: timeout counter too narrow");
    end

    // the interval step must be a whole number of clock cycles
    if (vpcr_pkg::NORESP_STEP_CYC * vpcr_pkg::CLK_PERIOD_NS != vpcr_pkg::NORESP_STEP_NS)
    begin : g_chk_clk
        $error("vpcr_regs: clock does not divide the timeout step");
    end

    if (REG_MAX * vpcr_pkg::PULSE_STEP_DNS >= (1 << AW) || vpcr_pkg::PULSE_DEF_DNS >= (1 << AW))
    begin : g_chk_pulse
        $error("vpcr_regs: pulse accumulator too narrow");
    end

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [7:0]    proto;
        logic [7:0]    pulse;
        logic [7:0]    tmo;
        logic [7:0]    rdata;
        logic          flag;
        logic          irq;
        logic          valid;
        logic          mod_on;
        logic [AW-1:0] acc;
    } vpcr_main_t;

    vpcr_main_t cur_ff;
    vpcr_main_t nxt_cur;

    logic          preset;
    logic          tmr_expire;
    logic [TW-1:0] tmo_target;
    logic [AW-1:0] pulse_target;

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // modulation pulse length in tenths of ns
    function automatic logic [AW-1:0] pulse_dns(input logic [7:0] len);
        if (len == 8'h00)
        begin
            pulse_dns = AW'(vpcr_pkg::PULSE_DEF_DNS);
        end
        else
        begin
            pulse_dns = AW'(len) * AW'(vpcr_pkg::PULSE_STEP_DNS);
        end
    endfunction

    // no-response interval in clock cycles
    function automatic logic [TW-1:0] tmo_cycles(input logic [7:0] val, input logic hi);
        if (val != 8'h00)
        begin
            tmo_cycles = TW'(val) * TW'(vpcr_pkg::NORESP_STEP_CYC);
        end
        else if (hi)
        begin
            tmo_cycles = TW'(NORESP_HI_CYC);
        end
        else
        begin
            tmo_cycles = TW'(NORESP_LO_CYC);
        end
    endfunction

    // codes above 7 and the reserved mode bit are not served
    function automatic logic code_ok(input logic [7:0] p);
        code_ok = !p[vpcr_pkg::BIT_CODE_HI]
               && !p[vpcr_pkg::BIT_CODE_MID]
               && !p[vpcr_pkg::BIT_RFID_RESERVED];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state

    assign preset       = por || !enable;
    assign pulse_target = pulse_dns(cur_ff.pulse);
    assign tmo_target   = tmo_cycles(cur_ff.tmo, cur_ff.proto[vpcr_pkg::BIT_HIGH_RATE]);

    always_comb
    begin
        nxt_cur = cur_ff;

        // host writes
        if (host_wr)
        begin
            unique case (host_addr)
                vpcr_pkg::ADDR_PROTOCOL_SELECT:
                begin
                    nxt_cur.proto = host_wdata;
                    nxt_cur.pulse = vpcr_pkg::RST_TX_PULSE_LENGTH;
                    nxt_cur.tmo   = vpcr_pkg::RST_NO_RESPONSE_TIMEOUT;
                end
                vpcr_pkg::ADDR_TX_PULSE_LENGTH:
                begin
                    nxt_cur.pulse = host_wdata;
                end
                vpcr_pkg::ADDR_NO_RESPONSE_TIMEOUT:
                begin
                    nxt_cur.tmo = host_wdata;
                end
                default:
                begin
                end
            endcase
        end

        // host reads, one cycle latency
        if (host_rd)
        begin
            unique case (host_addr)
                vpcr_pkg::ADDR_PROTOCOL_SELECT:
                begin
                    nxt_cur.rdata = cur_ff.proto;
                end
                vpcr_pkg::ADDR_TX_PULSE_LENGTH:
                begin
                    nxt_cur.rdata = cur_ff.pulse;
                end
                vpcr_pkg::ADDR_NO_RESPONSE_TIMEOUT:
                begin
                    nxt_cur.rdata = cur_ff.tmo;
                end
                vpcr_pkg::ADDR_IRQ_STATUS:
                begin
                    nxt_cur.rdata = vpcr_pkg::RDATA_UNMAPPED;
                    nxt_cur.rdata[vpcr_pkg::BIT_NO_RESPONSE_FLAG] = cur_ff.flag;
                end
                default:
                begin
                    nxt_cur.rdata = vpcr_pkg::RDATA_UNMAPPED;
                end
            endcase
        end

        // no-response flag: read of status clears, expiry in same cycle wins
        if (host_rd && host_addr == vpcr_pkg::ADDR_IRQ_STATUS)
        begin
            nxt_cur.flag = 1'b0;
        end
        if (tmr_expire)
        begin
            nxt_cur.flag = 1'b1;
        end
        nxt_cur.irq = nxt_cur.flag;

        // the pulse ends on the first edge at or past its length, so it rounds up
        // modulation pulse timer in tenths of ns
        if (tx_pulse_start)
        begin
            nxt_cur.mod_on = 1'b1;
            nxt_cur.acc    = AW'(vpcr_pkg::CLK_PERIOD_DNS);
        end
        else if (cur_ff.mod_on)
        begin
            if (cur_ff.acc >= pulse_target)
            begin
                nxt_cur.mod_on = 1'b0;
                nxt_cur.acc    = '0;
            end
            else
            begin
                nxt_cur.acc = cur_ff.acc + AW'(vpcr_pkg::CLK_PERIOD_DNS);
            end
        end

        // enable low or power-on reset overrides everything but the read data register
        if (preset)
        begin
            nxt_cur.proto  = vpcr_pkg::RST_PROTOCOL_SELECT;
            nxt_cur.pulse  = vpcr_pkg::RST_TX_PULSE_LENGTH;
            nxt_cur.tmo    = vpcr_pkg::RST_NO_RESPONSE_TIMEOUT;
            nxt_cur.flag   = 1'b0;
            nxt_cur.irq    = 1'b0;
            nxt_cur.mod_on = 1'b0;
            nxt_cur.acc    = '0;
        end

        // kept as a flop so the output leaves a register like its neighbours
        nxt_cur.valid = code_ok(nxt_cur.proto);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cur_ff       <= '0;
            cur_ff.proto <= vpcr_pkg::RST_PROTOCOL_SELECT;
            cur_ff.pulse <= vpcr_pkg::RST_TX_PULSE_LENGTH;
            cur_ff.tmo   <= vpcr_pkg::RST_NO_RESPONSE_TIMEOUT;
            cur_ff.valid <= code_ok(vpcr_pkg::RST_PROTOCOL_SELECT);
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // no-response timer

    vpcr_timer #(
        .CNT_W  (TW)
    // preset also abandons a running slot so no stale flag follows it
    ) u_vpcr_timer (
        .clk    (clk),
        .rst    (rst),
        .clr    (preset),
        .start  (tx_eof_done),
        .stop   (rx_resp_start),
        .target (tmo_target),
        .busy   (),
        .expire (tmr_expire)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign host_rdata        = cur_ff.rdata;
    assign mod_pulse         = cur_ff.mod_on;
    assign rx_no_crc         = cur_ff.proto[vpcr_pkg::BIT_RX_NO_CRC];
    assign direct_variant    = cur_ff.proto[vpcr_pkg::BIT_DIRECT_VARIANT];
    assign double_subcarrier = cur_ff.proto[vpcr_pkg::BIT_DOUBLE_SUB];
    assign high_rate         = cur_ff.proto[vpcr_pkg::BIT_HIGH_RATE];
    assign one_of_256        = cur_ff.proto[vpcr_pkg::BIT_ONE_OF_256];
    assign code_valid        = cur_ff.valid;
    assign no_resp_flag      = cur_ff.flag;
    assign no_resp_irq       = cur_ff.irq;

endmodule // vpcr_regs

`default_nettype wire

// ### design/vpcr_pkg.sv
/*
 * vpcr_pkg: register map, reset values, field positions and timing constants
 * of the vicinity protocol configuration register bank.
 * Assumes a single 50 MHz clock; pulse times stay in tenths of ns, only the timeout step is converted to cycles here.
 */
package vpcr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [4:0] ADDR_PROTOCOL_SELECT     = 5'h01;
    localparam logic [4:0] ADDR_TX_PULSE_LENGTH     = 5'h06;
    localparam logic [4:0] ADDR_NO_RESPONSE_TIMEOUT = 5'h07;
    localparam logic [4:0] ADDR_IRQ_STATUS          = 5'h0C;

    localparam logic [7:0] RST_PROTOCOL_SELECT      = 8'h02;
    localparam logic [7:0] RST_TX_PULSE_LENGTH      = 8'h00;
    localparam logic [7:0] RST_NO_RESPONSE_TIMEOUT  = 8'h0E;
    localparam logic [7:0] RDATA_UNMAPPED           = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // protocol_select fields
    localparam int BIT_RX_NO_CRC      = 7;
    localparam int BIT_DIRECT_VARIANT = 6;
    localparam int BIT_RFID_RESERVED  = 5;
    localparam int BIT_CODE_HI        = 4;
    localparam int BIT_CODE_MID       = 3;
    localparam int BIT_DOUBLE_SUB     = 2;
    localparam int BIT_HIGH_RATE      = 1;
    localparam int BIT_ONE_OF_256     = 0;

    // irq status fields
    localparam int BIT_NO_RESPONSE_FLAG = 0;

    ////////////////////////////////////////////////////////////////////////////
    // timing: clock
    localparam int unsigned CLK_MHZ        = 50;
    localparam int unsigned CLK_PERIOD_NS  = 1000 / CLK_MHZ;
    // pulse arithmetic in tenths of a nanosecond
    localparam int unsigned CLK_PERIOD_DNS = 10000 / CLK_MHZ;
    localparam int unsigned PULSE_STEP_DNS = 737;
    localparam int unsigned PULSE_DEF_DNS  = 94400;
    localparam int          PULSE_ACC_W    = 18;

    // no-response timer
    localparam int unsigned NORESP_STEP_NS   = 37760;
    localparam int unsigned NORESP_STEP_CYC  = NORESP_STEP_NS / CLK_PERIOD_NS;
    localparam int unsigned NORESP_DEF_HI_NS = 755000;
    localparam int unsigned NORESP_DEF_LO_NS = 1812000;
    localparam int          TMO_CNT_W        = 20;

endpackage

// ### design/vpcr_timer.sv
/*
 * vpcr_timer: one-shot cycle counter for the no-response interval.
 * Assumes start and stop are one-cycle pulses synchronous to clk and that
 * target is held stable while the timer runs; target of zero expires at the
 * first edge after start.
 */
`timescale 1ns/1ps
`default_nettype none

module vpcr_timer #(
    parameter int CNT_W = 20
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             clr,
    input  wire logic             start,
    input  wire logic             stop,
    input  wire logic [CNT_W-1:0] target,
    output logic                  busy,
    output logic                  expire
);

    if (CNT_W < 2)
    begin : g_chk
        $error("vpcr_timer: CNT_W too small");
    end

    typedef struct packed {
        logic             busy;
        logic             expire;
        logic [CNT_W-1:0] cnt;
    } vpcr_tmr_t;

    vpcr_tmr_t cur_ff;
    vpcr_tmr_t nxt_cur;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_cur        = cur_ff;
        nxt_cur.expire = 1'b0;
        if (clr || stop)
        begin
            nxt_cur.busy = 1'b0;
            nxt_cur.cnt  = '0;
        end
        else if (start)
        begin
            // each new slot re-arms from zero
            nxt_cur.busy = 1'b1;
            nxt_cur.cnt  = '0;
        end
        else if (cur_ff.busy)
        begin
            if (cur_ff.cnt + CNT_W'(1) >= target)
            begin
                nxt_cur.busy   = 1'b0;
                nxt_cur.expire = 1'b1;
            end
            else
            begin
                nxt_cur.cnt = cur_ff.cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cur_ff <= '0;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    assign busy   = cur_ff.busy;
    assign expire = cur_ff.expire;

endmodule // vpcr_timer

`default_nettype wire

// ### sim/vpcr_regs_monitor.sv
/* vpcr_regs_monitor: port assertions for the register bank.
   Bound into every vpcr_regs; sees only its ports, single clock domain. */
`timescale 1ns/1ps
`default_nettype none
module vpcr_regs_monitor #(
    parameter int unsigned NORESP_HI_CYC = 20,
    parameter int unsigned NORESP_LO_CYC = 40
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       enable,
    input wire logic       por,
    input wire logic [4:0] host_addr,
    input wire logic       host_wr,
    input wire logic       host_rd,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata,
    input wire logic       tx_pulse_start,
    input wire logic       tx_eof_done,
    input wire logic       rx_resp_start,
    input wire logic       mod_pulse,
    input wire logic       rx_no_crc,
    input wire logic       direct_variant,
    input wire logic       double_subcarrier,
    input wire logic       high_rate,
    input wire logic       one_of_256,
    input wire logic       code_valid,
    input wire logic       no_resp_flag,
    input wire logic       no_resp_irq
);
    logic       pre, wsel, rsts, arm_ff;
    logic [7:0] plen_ff, tmo_ff;
    int         prun_ff, pexp_ff, tcnt_ff, texp_ff;
    assign pre  = rst | ~enable | por;
    assign wsel = host_wr & (host_addr == 5'h01);
    assign rsts = host_rd & (host_addr == 5'h0C);
    ////////////////////////////////////////////////////////////
    // shadow registers and expected timer lengths
    always_ff @(posedge clk)
    begin
        if (pre || wsel)
        begin
            plen_ff <= 8'h00;
            tmo_ff  <= 8'h0E;
        end
        else if (host_wr && host_addr == 5'h06)
            plen_ff <= host_wdata;
        else if (host_wr && host_addr == 5'h07)
            tmo_ff <= host_wdata;
        prun_ff <= tx_pulse_start ? 0 : prun_ff + int'(mod_pulse);
        if (tx_pulse_start)
            pexp_ff <= (plen_ff == 8'h00) ? 472 : (int'(plen_ff) * 737 + 199) / 200;
        tcnt_ff <= tx_eof_done ? 0 : tcnt_ff + 1;
        if (tx_eof_done)
            texp_ff <= (tmo_ff != 8'h00) ? int'(tmo_ff) * 1888 :
                       high_rate ? int'(NORESP_HI_CYC) : int'(NORESP_LO_CYC);
        // stop wins over a start in the same cycle
        arm_ff <= !pre && !rx_resp_start && (arm_ff || tx_eof_done);
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_PRESET: assert property (!enable || por |=>
        {rx_no_crc, direct_variant, double_subcarrier, high_rate, one_of_256, code_valid} == 6'h05)
        else $error("preset did not restore protocol outputs");
    AST_NO_CRC: assert property (wsel && !pre |=> rx_no_crc == $past(host_wdata[7]))
        else $error("crc select does not follow bit 7");
    AST_VARIANT: assert property (wsel && !pre |=> direct_variant == $past(host_wdata[6]))
        else $error("direct variant does not follow bit 6");
    AST_CODE: assert property (wsel && !pre |=>
        {double_subcarrier, high_rate, one_of_256, code_valid} ==
        {$past(host_wdata[2:0]), $past(host_wdata[5:3]) == 3'h0})
        else $error("protocol code outputs wrong");
    AST_PULSE_LEN: assert property ($fell(mod_pulse) && !$past(pre) |->
        prun_ff == pexp_ff) else $error("modulation pulse length wrong");
    AST_RD_PLEN: assert property (host_rd && host_addr == 5'h06 |=>
        host_rdata == $past(plen_ff)) else $error("pulse length readback wrong");
    AST_RD_TMO: assert property (host_rd && host_addr == 5'h07 |=>
        host_rdata == $past(tmo_ff)) else $error("timeout readback wrong");
    AST_TMO: assert property ($rose(no_resp_flag) |->
        arm_ff && tcnt_ff == texp_ff + 1) else $error("no response flag at wrong time");
    AST_IRQ: assert property (no_resp_irq == no_resp_flag)
        else $error("irq differs from flag");
    AST_FLAG_HOLD: assert property ($fell(no_resp_flag) |-> $past(rsts) || $past(pre))
        else $error("flag cleared without status read");
endmodule // vpcr_regs_monitor
bind vpcr_regs vpcr_regs_monitor #(
    .NORESP_HI_CYC(NORESP_HI_CYC),
    .NORESP_LO_CYC(NORESP_LO_CYC)
) u_vpcr_regs_monitor (.*);
`default_nettype wire

// ### sim/vpcr_host.sv
/* vpcr_host: host controller model on the register port.
   Assumes strobes are taken at posedge clk; drives after each negedge. */
`timescale 1ns/1ps
`default_nettype none
module vpcr_host (
    input  wire logic       clk,
    output logic      [4:0] host_addr,
    output logic            host_wr,
    output logic            host_rd,
    output logic      [7:0] host_wdata,
    input  wire logic [7:0] host_rdata
);
    initial
    begin
        host_addr  = 5'h1F;
        host_wr    = 1'b0;
        host_rd    = 1'b0;
        host_wdata = 8'hFF;
    end
    // idle bus shows the inverse so stale values are never trusted
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge clk);
        host_addr  = a;
        host_wdata = (a == 5'h01) ? (d & 8'hDF) : d;
        host_wr    = 1'b1;
        @(negedge clk);
        host_wr    = 1'b0;
        host_addr  = ~a;
        host_wdata = ~d;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(negedge clk);
        host_addr = a;
        host_rd   = 1'b1;
        @(negedge clk);
        host_rd   = 1'b0;
        host_addr = ~a;
        d         = host_rdata;
    endtask
endmodule // vpcr_host
`default_nettype wire

// ### sim/tb_vpcr_regs.sv
/* tb_vpcr_regs: self-checking bench for the register bank.
   Host port through vpcr_host; other inputs driven at negedge. */
`timescale 1ns/1ps
`default_nettype none
module tb_vpcr_regs;
    localparam int HI = 20;
    localparam int LO = 40;
    logic       clk = 1'b0, rst = 1'b1, enable = 1'b1, por = 1'b0;
    logic       tx_pulse_start = 1'b0, tx_eof_done = 1'b0, rx_resp_start = 1'b0;
    logic       host_wr, host_rd, mod_pulse, rx_no_crc, direct_variant, double_subcarrier;
    logic       high_rate, one_of_256, code_valid, no_resp_flag, no_resp_irq;
    logic [4:0] host_addr;
    logic [7:0] host_wdata, host_rdata, d, v;
    logic [4:0] ra [4] = '{5'h01, 5'h06, 5'h07, 5'h02};
    logic [7:0] re [4] = '{8'h02, 8'h00, 8'h0E, 8'h00};
    int         n_fail = 0, total_checks = 0, cycles = 0, n;

    vpcr_regs #(.NORESP_HI_CYC(HI), .NORESP_LO_CYC(LO)) u_vpcr_regs (.*);
    vpcr_host u_host (.*);

    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles >= 20000)
        begin
            n_fail++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        total_checks++;
        if (got !== want)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic wrap_up();
        if (n_fail == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    function automatic int pcyc(input logic [7:0] p);
        return (p == 8'h00) ? 472 : (int'(p) * 737 + 199) / 200;
    endfunction
    task automatic pulse(input logic [7:0] p);
        u_host.wr(5'h06, p);
        tx_pulse_start = 1'b1;
        @(negedge clk);
        tx_pulse_start = 1'b0;
        n = 0;
        while (mod_pulse === 1'b1 && n < 1000)
        begin
            n++;
            @(negedge clk);
        end
        chk(n, pcyc(p));
    endtask
    // limit of 2000 cycles means no flag was seen
    task automatic tmo(input logic [7:0] t, input int stop_at, input int want);
        u_host.wr(5'h07, t);
        tx_eof_done = 1'b1;
        @(negedge clk);
        tx_eof_done = 1'b0;
        n = 0;
        while (no_resp_flag !== 1'b1 && n < 2000)
        begin
            rx_resp_start = (n == stop_at);
            @(negedge clk);
            n++;
        end
        rx_resp_start = 1'b0;
        chk(n, want);
        chk(no_resp_irq, want < 2000);
        u_host.rd(5'h0C, d);
        chk({d[0], no_resp_flag, no_resp_irq}, {want < 2000, 2'h0});
    endtask
    task automatic reg_table();
        foreach (ra[i])
        begin
            u_host.rd(ra[i], d);
            chk(d, re[i]);
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        v = 8'($urandom(96856));
        repeat (12) @(negedge clk);
        rst = 1'b0;
        reg_table();
        chk({rx_no_crc, direct_variant, double_subcarrier, high_rate, one_of_256}, 5'h02);
        for (int c = 0; c < 8; c++)
        begin
            v[7:6] = 2'($urandom);
            v[5:0] = 6'(c);
            u_host.wr(5'h01, v);
            chk(rx_no_crc, v[7]);
            chk(direct_variant, v[6]);
            chk({double_subcarrier, high_rate, one_of_256, code_valid}, {v[2:0], 1'b1});
        end
        u_host.wr(5'h01, 8'h18);
        chk({code_valid, high_rate}, 2'h0);
        u_host.wr(5'h06, 8'($urandom_range(255, 1)));
        u_host.wr(5'h07, 8'($urandom_range(255, 1)));
        u_host.wr(5'h01, 8'h02);
        u_host.rd(5'h06, d);
        chk(d, 8'h00);
        u_host.rd(5'h07, d);
        chk(d, 8'h0E);
        pulse(8'h01);
        pulse(8'h00);
        pulse(8'hFF);
        pulse(8'($urandom_range(254, 2)));
        tmo(8'h01, -1, 1889);
        tmo(8'h00, -1, HI + 1);
        tmo(8'h00, 5, 2000);
        u_host.wr(5'h01, 8'h00);
        tmo(8'h00, -1, LO + 1);
        for (int i = 0; i < 2; i++)
        begin
            u_host.wr(5'h01, 8'hC7);
            u_host.wr(5'h06, 8'h33);
            enable = (i != 0);
            por = (i != 0);
            @(negedge clk);
            enable = 1'b1;
            por = 1'b0;
            u_host.wr(5'h02, 8'($urandom));
            reg_table();
        end
        wrap_up();
    end
endmodule // tb_vpcr_regs
`default_nettype wire
